//--- logic/uart_channel_line.sv
// Contract
// - Loopback ignores the receive pin and feeds transmit serial to receiver.
// - Receive-ready goes low when received characters are available (block mode: at trigger level).
// - Receive-ready goes high when empty or, in block mode, below trigger level.
// - Transmit pin stays high in reset, idle, or transmitter disabled.
// - Loopback stops driving the transmit pin; data goes to receiver.
// - Transmit-ready goes low while a free transmit location exists.
// - Block mode: transmit-ready goes high when transmit buffer is full.
// - Both ready outputs also give valid status in single mode.
`include "uart_line_map.svh"
`default_nettype none
module uart_channel_line
    import uart_line_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial line
    input wire logic serial_in,
    output logic serial_out,
    // DMA status
    output logic receive_ready_n,
    output logic transmit_ready_n,
    // Control
    input wire logic loopback_en,
    input wire logic tx_enable,
    input wire logic dma_block_mode,
    input wire logic [4:0] rx_trigger_level,
    // Transmit data
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Receive data
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready
);
    // =================================================================
    // Oversample divider
    logic [`OS_DIV_W-1:0] div_q;
    logic os_tick_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
            os_tick_q <= 1'b0;
        end else if (div_q == `OS_DIV_W'(`OS_DIV - 1)) begin
            div_q <= '0;
            os_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 1'b1;
            os_tick_q <= 1'b0;
        end
    end

    // =================================================================
    // Transmit buffer
    logic [7:0] txf_data;
    logic txf_valid;
    logic txf_pop;
    logic txf_full;
    logic [`CNT_W-1:0] txf_count;

    sync_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_tx_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(txf_data),
        .out_valid(txf_valid),
        .out_ready(txf_pop),
        .count(txf_count),
        .full(txf_full)
    );

    // =================================================================
    // Transmitter
    tx_state_t tx_state_q;
    logic [7:0] tx_shift_q;
    logic [3:0] tx_os_q;
    logic [2:0] tx_bit_q;
    logic tx_line_q;
    logic tx_last;

    // Frames start only from idle, so a disable starts no new frame; one in flight runs on with the pin held idle
    assign txf_pop = (tx_state_q == TX_IDLE) && tx_enable && txf_valid;
    assign tx_last = os_tick_q && (tx_os_q == `OS_LAST);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_q <= TX_IDLE;
            tx_shift_q <= '0;
            tx_os_q <= '0;
            tx_bit_q <= '0;
            tx_line_q <= `LINE_IDLE;
        end else begin
            if (os_tick_q) begin
                tx_os_q <= tx_os_q + 1'b1;
            end
            case (tx_state_q)
                TX_IDLE: begin
                    tx_line_q <= `LINE_IDLE;
                    if (txf_pop) begin
                        tx_shift_q <= txf_data;
                        tx_os_q <= '0;
                        tx_bit_q <= '0;
                        tx_line_q <= 1'b0;
                        tx_state_q <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_last) begin
                        tx_line_q <= tx_shift_q[0];
                        tx_state_q <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_last) begin
                        if (tx_bit_q == `BIT_LAST) begin
                            tx_line_q <= `LINE_IDLE;
                            tx_state_q <= TX_STOP;
                        end else begin
                            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                            tx_line_q <= tx_shift_q[1];
                            tx_bit_q <= tx_bit_q + 1'b1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_last) begin
                        tx_state_q <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end

    // Pin held idle in loopback or when disabled
    logic serial_out_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_q <= `LINE_IDLE;
        end else if (loopback_en || !tx_enable) begin
            serial_out_q <= `LINE_IDLE;
        end else begin
            serial_out_q <= tx_line_q;
        end
    end

    assign serial_out = serial_out_q;

    // =================================================================
    // Receive input synchroniser and source select
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_src;

    // Reset to idle so a held-high line never looks like a start bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= `LINE_IDLE;
            rx_sync_q <= `LINE_IDLE;
        end else begin
            rx_meta_q <= serial_in;
            rx_sync_q <= rx_meta_q;
        end
    end

    assign rx_src = loopback_en ? tx_line_q : rx_sync_q;

    // =================================================================
    // Receiver
    rx_state_t rx_state_q;
    logic [7:0] rx_shift_q;
    logic [3:0] rx_os_q;
    logic [2:0] rx_bit_q;
    logic rx_push_q;
    logic [7:0] rx_byte_q;
    logic rx_last;

    assign rx_last = os_tick_q && (rx_os_q == `OS_LAST);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= RX_IDLE;
            rx_shift_q <= '0;
            rx_os_q <= '0;
            rx_bit_q <= '0;
            rx_push_q <= 1'b0;
            rx_byte_q <= '0;
        end else begin
            rx_push_q <= 1'b0;
            if (os_tick_q) begin
                rx_os_q <= rx_os_q + 1'b1;
            end
            case (rx_state_q)
                RX_IDLE: begin
                    rx_os_q <= '0;
                    if (!rx_src) begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (os_tick_q && rx_os_q == `OS_MID) begin
                        rx_os_q <= '0;
                        rx_bit_q <= '0;
                        // Glitch shorter than half a bit is rejected
                        rx_state_q <= rx_src ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_last) begin
                        rx_shift_q <= {rx_src, rx_shift_q[7:1]};
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == `BIT_LAST) begin
                            rx_state_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_last) begin
                        // Bad stop bit drops the character
                        rx_push_q <= rx_src;
                        rx_byte_q <= rx_shift_q;
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= RX_IDLE;
                end
            endcase
        end
    end

    // =================================================================
    // Receive buffer; a character arriving while full is lost
    logic [`CNT_W-1:0] rxf_count;
    logic rxf_full;

    sync_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_rx_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_data(rx_byte_q),
        .in_valid(rx_push_q),
        .in_ready(),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .count(rxf_count),
        .full(rxf_full)
    );

    // =================================================================
    // DMA ready status
    logic [`CNT_W-1:0] trig_eff;
    logic rx_avail;
    logic receive_ready_n_q;
    logic transmit_ready_n_q;

    // A trigger of zero would assert with nothing to read
    assign trig_eff = (rx_trigger_level == `CNT_ZERO) ? `TRIG_MIN
                                                      : rx_trigger_level;
    assign rx_avail = dma_block_mode ? (rxf_count >= trig_eff)
                                     : (rxf_count != `CNT_ZERO);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            receive_ready_n_q <= 1'b1;
            transmit_ready_n_q <= 1'b1;
        end else begin
            receive_ready_n_q <= !rx_avail;
            transmit_ready_n_q <= txf_full;
        end
    end

    assign receive_ready_n = receive_ready_n_q;
    assign transmit_ready_n = transmit_ready_n_q;

    // =================================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Idle transmitter in loopback keeps the receiver idle whatever the pin
    property p_loop_src;
        (loopback_en && rx_state_q == RX_IDLE && tx_line_q)
            |=> (rx_state_q == RX_IDLE);
    endproperty
    a_loop_src: assert property (p_loop_src)
        else $error("loopback receiver not fed from transmitter");

    property p_loop_pin;
        loopback_en ##1 loopback_en |-> serial_out_q;
    endproperty
    a_loop_pin: assert property (p_loop_pin)
        else $error("transmit pin driven during loopback");

    property p_rx_avail;
        (rxf_count >= trig_eff) |=> !receive_ready_n_q;
    endproperty
    a_rx_avail: assert property (p_rx_avail)
        else $error("receive ready not low with data at trigger");

    property p_rx_empty;
        (rxf_count == `CNT_ZERO) |=> receive_ready_n_q;
    endproperty
    a_rx_empty: assert property (p_rx_empty)
        else $error("receive ready low while buffer empty");

    property p_rx_trig;
        (dma_block_mode && rxf_count < trig_eff) |=> receive_ready_n_q;
    endproperty
    a_rx_trig: assert property (p_rx_trig)
        else $error("receive ready low below trigger level");

    property p_tx_off;
        !tx_enable ##1 !tx_enable |-> serial_out_q;
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("transmit pin low while transmitter disabled");

    property p_tx_free;
        !txf_full |=> !transmit_ready_n_q;
    endproperty
    a_tx_free: assert property (p_tx_free)
        else $error("transmit ready high with free location");

    property p_tx_full;
        (dma_block_mode && txf_full) |=> transmit_ready_n_q;
    endproperty
    a_tx_full: assert property (p_tx_full)
        else $error("transmit ready low with buffer full");

    property p_single;
        (!dma_block_mode && rxf_count != `CNT_ZERO && txf_full)
            |=> (!receive_ready_n_q && transmit_ready_n_q);
    endproperty
    a_single: assert property (p_single)
        else $error("ready status wrong in single mode");

    c_loop_char: cover property (loopback_en && rx_push_q);
    c_tx_full: cover property (txf_full && !transmit_ready_n_q ##1
                               transmit_ready_n_q);
    c_rx_full: cover property (rxf_full);
    c_block_trig: cover property (dma_block_mode && receive_ready_n_q
                                  ##1 !receive_ready_n_q);
endmodule
`default_nettype wire

//--- logic/uart_line_map.svh
`ifndef UART_LINE_MAP_SVH
`define UART_LINE_MAP_SVH

// =====================================================================
// Clock and line rate
`define CLOCK_HZ 125000000
`define BAUD_RATE 115200
`define OS_RATE 16
`define OS_DIV (`CLOCK_HZ / (`BAUD_RATE * `OS_RATE))
`define OS_DIV_W 7

// =====================================================================
// Frame timing in oversample ticks and data bit index
`define OS_MID 4'h7
`define OS_LAST 4'hF
`define BIT_LAST 3'h7

// =====================================================================
// Data path
`define DATA_W 8
`define FIFO_DEPTH 16
`define CNT_W 5
`define LINE_IDLE 1'b1
`define TRIG_MIN 5'h01
`define CNT_ZERO 5'h00

`endif

//--- logic/uart_line_pkg.sv
`default_nettype none
package uart_line_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } rx_state_t;
endpackage
`default_nettype wire

//--- logic/sync_fifo.sv
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    // Status
    output logic [$clog2(DEPTH):0] count,
    output logic full
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic full_q;
    logic valid_q;
    logic ready_q;
    logic push;
    logic pop;
    logic [AW:0] count_d;

    // Flags kept as their own flops so the handshake outputs are registered
    assign push = in_valid && ready_q;
    assign pop = out_ready && valid_q;
    assign in_ready = ready_q;
    assign out_valid = valid_q;
    assign out_data = mem_q[rd_ptr_q];
    assign count = count_q;
    assign full = full_q;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            full_q <= 1'b0;
            valid_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            full_q <= (count_d == (AW+1)'(DEPTH));
            ready_q <= (count_d != (AW+1)'(DEPTH));
            valid_q <= (count_d != '0);
        end
    end
endmodule
`default_nettype wire

//--- tb/uart_far_end.sv
`default_nettype none
module uart_far_end #(
    parameter int BIT_CLKS = 1072
) (
    // Clock
    input wire logic clock,
    // Serial lines
    input wire logic jam,
    input wire logic line_from_dut,
    output logic line_to_dut
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==================================================================
    // Line driver
    logic drive_q = 1'b1; // Idle high outside frames
    // Jam pulls the line low so loopback can show the pin is ignored
    assign line_to_dut = jam ? 1'b0 : drive_q;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clock);
            drive_q = frame[i]; // Stop bit leaves line high
            repeat (BIT_CLKS - 1) @(negedge clock);
        end
    endtask

    // ==================================================================
    // Line monitor
    // Mid-bit sampling tolerates the short first start bit
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        for (int n = 0; n < 2 * BIT_CLKS && !ok; n++) begin
            @(negedge clock);
            ok = (line_from_dut === 1'b0);
        end
        repeat (BIT_CLKS / 2) @(negedge clock);
        if (line_from_dut !== 1'b0) ok = 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(negedge clock);
            b[i] = line_from_dut;
        end
        repeat (BIT_CLKS) @(negedge clock);
        if (line_from_dut !== 1'b1) ok = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb/uart_channel_line_and_ready_status_bench.sv
`default_nettype none
module uart_channel_line_and_ready_status_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock, rst_n, serial_in, serial_out, jam;
    logic receive_ready_n, transmit_ready_n;
    logic loopback_en, tx_enable, dma_block_mode;
    logic [4:0] rx_trigger_level;
    logic [7:0] tx_data, rx_data, got_b;
    logic tx_valid, tx_ready, rx_valid, rx_ready, got_ok;
    int error_cnt = 0;
    int checks_done = 0;

    uart_channel_line u_uart_channel_line (
        .clock(clock), .rst_n(rst_n), .serial_in(serial_in),
        .serial_out(serial_out), .receive_ready_n(receive_ready_n),
        .transmit_ready_n(transmit_ready_n), .loopback_en(loopback_en),
        .tx_enable(tx_enable), .dma_block_mode(dma_block_mode),
        .rx_trigger_level(rx_trigger_level), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready)
    );

    uart_far_end u_uart_far_end (
        .clock(clock), .jam(jam), .line_from_dut(serial_out),
        .line_to_dut(serial_in)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ==================================================================
    // Shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_up(input logic hit, input string name);
        if (!hit) begin
            error_cnt++;
            $display("[FAIL] %s expected 1 seen 0", name);
            finish_test();
        end
    endtask

    // Holds valid across back-to-back bytes; refused bytes stay offered
    task automatic push_run(input logic [7:0] first, input int n);
        int k;
        @(negedge clock);
        for (int i = 0; i < n; i++) begin
            tx_valid = 1'b1;
            tx_data = first + 8'(i);
            for (k = 0; k < 2000 && tx_ready !== 1'b1; k++) @(negedge clock);
            give_up(k < 2000, "tx_ready wait");
            @(negedge clock);
        end
        tx_valid = 1'b0;
    endtask

    task automatic pop_byte();
        @(negedge clock);
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
    endtask

    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (3) @(negedge clock);
        chk("reset serial_out", 8'h01, 8'(serial_out));
        chk("reset tx rdy_n", 8'h01, 8'(transmit_ready_n));
        chk("reset rx rdy_n", 8'h01, 8'(receive_ready_n));
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        chk("idle tx rdy_n", 8'h00, 8'(transmit_ready_n));
        chk("idle rx rdy_n", 8'h01, 8'(receive_ready_n));
        chk("idle serial_out", 8'h01, 8'(serial_out));
        $display("test reset done");
    endtask

    // ==================================================================
    // Scenarios
    task automatic test_tx();
        push_run(8'hA5, 1);
        u_uart_far_end.recv_byte(got_b, got_ok);
        chk("tx framing", 8'h01, 8'(got_ok));
        chk("tx byte", 8'hA5, got_b);
        repeat (4) @(negedge clock);
        chk("tx idle", 8'h01, 8'(serial_out));
        $display("test tx done");
    endtask

    task automatic test_rx_single();
        dma_block_mode = 1'b0;
        rx_trigger_level = 5'h01;
        u_uart_far_end.send_byte(8'h3C);
        repeat (4) @(negedge clock);
        chk("rx valid", 8'h01, 8'(rx_valid));
        chk("rx rdy_n single", 8'h00, 8'(receive_ready_n));
        chk("rx byte", 8'h3C, rx_data);
        pop_byte();
        repeat (3) @(negedge clock);
        chk("rx rdy_n empty", 8'h01, 8'(receive_ready_n));
        $display("test rx single done");
    endtask

    task automatic test_rx_trigger();
        dma_block_mode = 1'b1;
        rx_trigger_level = 5'h02;
        u_uart_far_end.send_byte(8'h81);
        repeat (4) @(negedge clock);
        chk("trig valid", 8'h01, 8'(rx_valid));
        chk("below trigger", 8'h01, 8'(receive_ready_n));
        u_uart_far_end.send_byte(8'h7E);
        repeat (4) @(negedge clock);
        chk("at trigger", 8'h00, 8'(receive_ready_n));
        chk("trig head", 8'h81, rx_data);
        pop_byte();
        repeat (3) @(negedge clock);
        chk("back below", 8'h01, 8'(receive_ready_n));
        rx_trigger_level = 5'h00;
        repeat (2) @(negedge clock);
        chk("zero trigger", 8'h00, 8'(receive_ready_n));
        chk("trig second", 8'h7E, rx_data);
        pop_byte();
        $display("test rx trigger done");
    endtask

    task automatic test_loopback();
        int n;
        int lows;
        lows = 0;
        dma_block_mode = 1'b0;
        loopback_en = 1'b1;
        repeat (3) @(negedge clock);
        jam = 1'b1;
        push_run(8'h5A, 1);
        for (n = 0; n < 12000 && rx_valid !== 1'b1; n++) begin
            @(negedge clock);
            if (serial_out !== 1'b1) lows++;
        end
        give_up(n < 12000, "loopback rx wait");
        chk("loop pin", 8'h00, 8'(lows != 0));
        chk("loop byte", 8'h5A, rx_data);
        pop_byte();
        jam = 1'b0;
        repeat (2) @(negedge clock);
        loopback_en = 1'b0;
        repeat (3) @(negedge clock);
        $display("test loopback done");
    endtask

    task automatic test_full();
        int n;
        tx_enable = 1'b0;
        dma_block_mode = 1'b1;
        push_run(8'h10, 16);
        repeat (3) @(negedge clock);
        chk("full tx_ready", 8'h00, 8'(tx_ready));
        chk("full rdy_n block", 8'h01, 8'(transmit_ready_n));
        chk("disabled pin", 8'h01, 8'(serial_out));
        dma_block_mode = 1'b0;
        repeat (2) @(negedge clock);
        chk("full rdy_n single", 8'h01, 8'(transmit_ready_n));
        tx_enable = 1'b1;
        for (n = 0; n < 2000 && transmit_ready_n !== 1'b0; n++) begin
            @(negedge clock);
        end
        chk("space rdy_n", 8'h00, 8'(transmit_ready_n));
        $display("test full done");
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        jam = 1'b0;
        loopback_en = 1'b0;
        tx_enable = 1'b1;
        dma_block_mode = 1'b0;
        rx_trigger_level = 5'h01;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        do_reset();
        test_tx();
        test_rx_single();
        test_rx_trigger();
        test_loopback();
        test_full();
        // Mid-frame reset must bring the pin straight back to idle
        do_reset();
        finish_test();
    end
endmodule
`default_nettype wire
